// File: rtl/dram_host_ctrl.sv
// Host controller driving a DRAM controller/driver in automatic access mode with hidden and forced refresh
//
// Contract
// - Host drives write level to pick read or write for each access
// - In external refresh mode host ties refresh clock high, enters refresh, strobes
// - Host keeps chip select high for the whole hidden refresh strobe
// - Host answers a refresh request at once, while refresh clock is low; here a request that comes during an access waits until the access ends
// - Host never mixes refresh and access; each waits for the other
// - Host asserts chip select before it lowers the row strobe
// - Host pulses row strobe in idle cycles to provoke hidden refreshes
// - Host ties address latch strobe high so latches pass addresses through
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "dram_host_map.svh"
module dram_host_ctrl
   import dram_host_pkg::*;
#(
   parameter int REFRESH_PERIOD = `REFRESH_CLOCK_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Device pins
   output logic row_strobe_in_n,
   output logic write_in_n,
   output logic cs_n,
   output logic row_hold_select,
   output logic address_latch_strobe,
   output logic refresh_select_n,
   output logic refresh_clock_in,
   output logic refresh_gen_clock,
   output logic [9:0] row_addr_in,
   output logic [9:0] col_addr_in,
   output logic bank_sel_lo,
   output logic bank_sel_hi,
   input wire logic refresh_request_n
);

   ctrl_t ctrl_reg;
   dram_addr_t addr_reg;
   state_t state_reg, state_next;
   logic [7:0] cnt_reg, cnt_next;
   logic start_pend_reg, ext_pend_reg, hidden_done_reg, done_reg;
   logic [7:0] refresh_cnt_reg;
   logic refresh_clock_in_level, refresh_clock_in_fall, refresh_clock_in_rise, refresh_gen_clock_level;

   ////////////////////////////////////////////////////////////////////////////
   // Dividers for refresh clock and refresh generation clock
   clock_divider #(.PERIOD(REFRESH_PERIOD), .HIGH(REFRESH_PERIOD / 2)) u_refresh_clock_in (
      .clock(clock), .rst_n(rst_n), .level(refresh_clock_in_level), .fall_pulse(refresh_clock_in_fall), .rise_pulse(refresh_clock_in_rise));
   clock_divider #(.PERIOD(`GEN_CLOCK_CYC), .HIGH(`GEN_CLOCK_CYC / 2)) u_refresh_gen_clock (
      .clock(clock), .rst_n(rst_n), .level(refresh_gen_clock_level), .fall_pulse(), .rise_pulse());

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; zero-wait access phase, pready raised by the setup cycle
   wire setup_cyc = psel && !penable;
   wire wr_take = psel && penable && pready && pwrite;
   wire sel_ctrl = (paddr == `REG_CTRL);
   wire sel_addr = (paddr == `REG_ADDR);
   wire sel_status = (paddr == `REG_STATUS);
   wire mapped = sel_ctrl || sel_addr || sel_status;
   wire start_wr = wr_take && sel_ctrl && pwdata[`CTRL_START_BIT];
   wire done_clr = wr_take && sel_status && pwdata[`STATUS_DONE_BIT];
   wire busy = (state_reg != ST_IDLE);
   wire refreshing = (state_reg == ST_FORCED) || (state_reg == ST_EXTREF) || (state_reg == ST_HIDDEN);
   wire [31:0] status_word = {16'h0000, refresh_cnt_reg, 4'h0, !refresh_request_n, refreshing, done_reg, busy};
   wire [31:0] rd_word = sel_ctrl ? {ctrl_reg[31:1], 1'b0} : (sel_addr ? addr_reg : status_word);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         ctrl_reg <= `CTRL_RESET_VAL;
         addr_reg <= 32'h0000_0000;
      end else begin
         pready <= setup_cyc;
         pslverr <= setup_cyc && !mapped;
         prdata <= (setup_cyc && !pwrite && mapped) ? rd_word : 32'h0000_0000;
         if (wr_take && sel_ctrl) ctrl_reg <= {27'h0000000, pwdata[4:1], 1'b0};
         if (wr_take && sel_addr && !busy) addr_reg <= {10'h000, pwdata[21:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   wire req_seen = !refresh_request_n && !ctrl_reg.ext_refresh;
   wire hidden_ok = ctrl_reg.hidden_en && !ctrl_reg.ext_refresh && refresh_clock_in_level && !hidden_done_reg;

   always_comb begin
      state_next = state_reg;
      cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
      unique case (state_reg)
         ST_IDLE: begin
            if (req_seen) begin
               state_next = ST_FORCED;
               cnt_next = 8'(`FORCED_CYC - 1);
            end else if (ext_pend_reg) begin
               state_next = ST_EXTREF;
               cnt_next = 8'(`STROBE_LOW_CYC + 1);
            end else if (start_pend_reg) begin
               state_next = ST_SETUP;
               cnt_next = 8'(`CS_SETUP_CYC - 1);
            end else if (hidden_ok) begin
               state_next = ST_HIDDEN;
               cnt_next = 8'(`STROBE_LOW_CYC - 1);
            end
         end
         ST_SETUP: if (cnt_reg == 8'h00) begin
            state_next = ST_STROBE;
            cnt_next = 8'(`STROBE_LOW_CYC - 1);
         end
         ST_STROBE: if (cnt_reg == 8'h00) begin
            state_next = ST_PRECH;
            cnt_next = 8'(`PRECHARGE_CYC - 1);
         end
         ST_PRECH: if (cnt_reg == 8'h00) state_next = ST_IDLE;
         ST_HIDDEN, ST_FORCED: if (cnt_reg == 8'h00) begin
            state_next = ST_RECOVER;
            cnt_next = 8'(`PRECHARGE_CYC - 1);
         end
         ST_EXTREF: if (cnt_reg == 8'h00) begin
            state_next = ST_RECOVER;
            cnt_next = 8'(`PRECHARGE_CYC - 1);
         end
         ST_RECOVER: if (cnt_reg == 8'h00) state_next = ST_IDLE;
      endcase
   end

   // Pending events: a set in the cycle of the clear wins
   wire access_end = (state_reg == ST_PRECH) && (cnt_reg == 8'h00);
   wire any_refresh_end = (state_next == ST_RECOVER) && (state_reg != ST_RECOVER);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 8'h00;
         start_pend_reg <= 1'b0;
         ext_pend_reg <= 1'b0;
         hidden_done_reg <= 1'b0;
         done_reg <= 1'b0;
         refresh_cnt_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         start_pend_reg <= start_wr || (start_pend_reg && state_next != ST_SETUP);
         ext_pend_reg <= (refresh_clock_in_fall && ctrl_reg.ext_refresh) || (ext_pend_reg && state_next != ST_EXTREF);
         hidden_done_reg <= (state_next == ST_HIDDEN) || (hidden_done_reg && !refresh_clock_in_rise);
         done_reg <= access_end || (done_reg && !done_clr);
         if (any_refresh_end) refresh_cnt_reg <= refresh_cnt_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive, all registered; strobe edges land one cycle after the state
   wire ext_strobe = (state_reg == ST_EXTREF) && (cnt_reg != 8'h00) && (cnt_reg <= 8'(`STROBE_LOW_CYC));
   wire strobe_low = (state_reg == ST_STROBE) || (state_reg == ST_HIDDEN) || ext_strobe;
   wire local_cyc = (state_reg == ST_SETUP) || (state_reg == ST_STROBE) || (state_reg == ST_PRECH);
   wire select_low = (state_reg == ST_FORCED) || (state_reg == ST_EXTREF);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         row_strobe_in_n <= 1'b1;
         write_in_n <= 1'b1;
         cs_n <= 1'b1;
         row_hold_select <= 1'b1;
         address_latch_strobe <= 1'b1;
         refresh_select_n <= 1'b1;
         refresh_clock_in <= 1'b1;
         refresh_gen_clock <= 1'b1;
         row_addr_in <= 10'h000;
         col_addr_in <= 10'h000;
         bank_sel_lo <= 1'b0;
         bank_sel_hi <= 1'b0;
      end else begin
         row_strobe_in_n <= !strobe_low;
         write_in_n <= local_cyc ? !ctrl_reg.write : 1'b1;
         cs_n <= !local_cyc;
         row_hold_select <= ctrl_reg.row_hold_sel;
         address_latch_strobe <= 1'b1;
         refresh_select_n <= !select_low;
         refresh_clock_in <= ctrl_reg.ext_refresh ? 1'b1 : refresh_clock_in_level;
         refresh_gen_clock <= refresh_gen_clock_level;
         row_addr_in <= addr_reg.row;
         col_addr_in <= addr_reg.col;
         bank_sel_lo <= addr_reg.bank[0];
         bank_sel_hi <= addr_reg.bank[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_cs_before_strobe: assert property (@(posedge clock) disable iff (!rst_n)
      ($fell(row_strobe_in_n) && !cs_n) |-> $past(!cs_n)) else $error("row strobe fell with chip select");
   a_hidden_cs_high: assert property (@(posedge clock) disable iff (!rst_n)
      (!row_strobe_in_n && cs_n) |=> (cs_n || row_strobe_in_n)) else $error("cs low in hidden");
   a_strobe_low_len: assert property (@(posedge clock) disable iff (!rst_n)
      $fell(row_strobe_in_n) |-> !row_strobe_in_n[*8]) else $error("row strobe pulse too short");
   a_forced_on_request: assert property (@(posedge clock) disable iff (!rst_n)
      (state_reg == ST_IDLE && req_seen) |=> ##1 !refresh_select_n) else $error("request not answered");
   a_forced_no_strobe: assert property (@(posedge clock) disable iff (!rst_n)
      (state_reg == ST_FORCED) |=> row_strobe_in_n) else $error("strobe during forced refresh");
   a_refresh_no_access: assert property (@(posedge clock) disable iff (!rst_n)
      !refresh_select_n |-> cs_n) else $error("access during refresh");
   a_select_bounded: assert property (@(posedge clock) disable iff (!rst_n)
      $fell(refresh_select_n) |-> !refresh_select_n[*8] ##[1:40] refresh_select_n) else $error("refresh length");
   a_exit_gap: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(refresh_select_n) |-> (row_strobe_in_n && cs_n)[*2]) else $error("access too soon after refresh");
   a_write_stable: assert property (@(posedge clock) disable iff (!rst_n)
      (!row_strobe_in_n && !cs_n) |-> $stable(write_in_n)) else $error("write level moved in access");
   a_ext_clock_high: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl_reg.ext_refresh |=> refresh_clock_in) else $error("refresh clock not tied high");
   a_ext_strobe_in: assert property (@(posedge clock) disable iff (!rst_n)
      ($rose(row_strobe_in_n) && $past(ext_strobe, 2)) |-> !refresh_select_n) else $error("strobe rose outside refresh");
   a_latch_open: assert property (@(posedge clock) disable iff (!rst_n)
      address_latch_strobe) else $error("address latch strobe low");

endmodule : dram_host_ctrl

// File: rtl/dram_host_map.svh
// Register offsets, field positions, reset values and timing counts of the DRAM host controller
`ifndef DRAM_HOST_MAP_SVH
`define DRAM_HOST_MAP_SVH

`define CLK_PERIOD_NS 20
`define REG_CTRL 12'h000
`define REG_ADDR 12'h004
`define REG_STATUS 12'h008
`define CTRL_START_BIT 0
`define CTRL_RESET_VAL 32'h0000_0010
`define STATUS_DONE_BIT 1
`define STROBE_LOW_NS 200
`define STROBE_LOW_CYC ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRECHARGE_NS 100
`define PRECHARGE_CYC ((`PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_SETUP_NS 20
`define CS_SETUP_CYC ((`CS_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FORCED_NS 500
`define FORCED_CYC ((`FORCED_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_EXIT_TO_ACCESS_NS 40
`define REFRESH_EXIT_TO_ACCESS_CYC ((`REFRESH_EXIT_TO_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_CLOCK_NS 16000
`define REFRESH_CLOCK_CYC (`REFRESH_CLOCK_NS / `CLK_PERIOD_NS)
`define GEN_CLOCK_NS 100
`define GEN_CLOCK_CYC (`GEN_CLOCK_NS / `CLK_PERIOD_NS)

`endif

// File: rtl/dram_host_pkg.sv
// Types shared by the DRAM host controller files
package dram_host_pkg;

   typedef struct packed {
      logic [26:0] unused;
      logic row_hold_sel;
      logic ext_refresh;
      logic hidden_en;
      logic write;
      logic start;
   } ctrl_t;

   typedef struct packed {
      logic [9:0] unused;
      logic [1:0] bank;
      logic [9:0] col;
      logic [9:0] row;
   } dram_addr_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_STROBE = 3'b010,
      ST_PRECH = 3'b011,
      ST_HIDDEN = 3'b100,
      ST_FORCED = 3'b101,
      ST_EXTREF = 3'b110,
      ST_RECOVER = 3'b111
   } state_t;

endpackage : dram_host_pkg

// File: rtl/clock_divider.sv
// Square-wave divider with a one-cycle pulse at each falling and rising edge of its output
`timescale 1ns/1ps
module clock_divider
   import dram_host_pkg::*;
#(
   parameter int PERIOD = 800,
   parameter int HIGH = 400
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Divided output
   output logic level,
   output logic fall_pulse,
   output logic rise_pulse
);

   logic [15:0] cnt_reg;
   wire last_cnt = (cnt_reg == 16'(PERIOD - 1));
   wire high_end = (cnt_reg == 16'(HIGH - 1));

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_reg <= 16'h0000;
         level <= 1'b1;
         fall_pulse <= 1'b0;
         rise_pulse <= 1'b0;
      end else begin
         cnt_reg <= last_cnt ? 16'h0000 : cnt_reg + 16'h0001;
         level <= high_end ? 1'b0 : (last_cnt ? 1'b1 : level);
         fall_pulse <= high_end;
         rise_pulse <= last_cnt;
      end
   end

endmodule : clock_divider

// File: tb/dram_device_model.sv
// Behavioural model of the refresh side of the DRAM controller/driver
`timescale 1ns/1ps
module dram_device_model (
   // Host side pins
   input wire logic row_strobe_in_n,
   input wire logic cs_n,
   input wire logic refresh_select_n,
   input wire logic refresh_clock_in,
   input wire logic refresh_gen_clock,
   // Refresh handshake and observation
   output logic refresh_request_n,
   output logic [7:0] refresh_count
);
   logic refreshed;
   logic ext_mode;
   int gen_falls;

   initial begin
      refresh_request_n = 1'b1;
      refresh_count = 8'h00;
      refreshed = 1'b0;
      ext_mode = 1'b0;
      gen_falls = 0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // A new refresh clock period may earn one hidden refresh again
   always @(posedge refresh_clock_in) refreshed = 1'b0;
   // Only one hidden refresh per period; once begun it is counted even if the refresh clock falls
   always @(negedge row_strobe_in_n) begin
      if (cs_n && refresh_clock_in && refresh_select_n && !refreshed) begin
         refreshed = 1'b1;
         refresh_count = refresh_count + 8'h01;
      end
   end
   always @(negedge refresh_clock_in) begin
      if (!refreshed) refresh_request_n = 1'b0;
   end
   // Refresh clock held high at entry marks the external refresh mode
   always @(negedge refresh_select_n) begin
      ext_mode = refresh_clock_in;
      gen_falls = 0;
      if (ext_mode) refresh_request_n = 1'b1;
   end
   always @(posedge row_strobe_in_n) begin
      if (!refresh_select_n && ext_mode) refresh_count = refresh_count + 8'h01;
   end
   // Forced refresh needs no control beyond the select line; column strobe never moves
   always @(negedge refresh_gen_clock) begin
      if (!refresh_select_n && !ext_mode) begin
         gen_falls = gen_falls + 1;
         if (gen_falls == 2) begin
            refresh_request_n = 1'b1;
            refresh_count = refresh_count + 8'h01;
         end
      end
   end
endmodule : dram_device_model

// File: tb/dram_auto_access_refresh_bench.sv
// Self-checking bench of the DRAM host controller with a device model
`timescale 1ns/1ps
`include "dram_host_map.svh"
`define CHECK(act, exp) begin n_compared++; if ((act) !== (exp)) begin n_errors++; \
   $display("[ERR] %0t act=%h exp=%h", $time, (act), (exp)); end end
module dram_auto_access_refresh_bench;
   import dram_host_pkg::*;
   // Short refresh period keeps the run small but leaves a forced refresh room in the low phase
   localparam int PERIOD = 200;
   typedef struct packed {logic err; logic [31:0] data; logic [31:0] mask;} expect_t;
   expect_t exp_q[$];
   expect_t ex;
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, a;
   logic row_strobe_in_n, write_in_n, cs_n, row_hold_select, address_latch_strobe, refresh_select_n;
   logic refresh_clock_in, refresh_gen_clock, bank_sel_lo, bank_sel_hi, refresh_request_n, w, h, prev, ok;
   logic [9:0] row_addr_in, col_addr_in;
   logic [7:0] refresh_count, c0;
   int n_errors, n_compared, i, t, falls;

   dram_host_ctrl #(.REFRESH_PERIOD(PERIOD)) u_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .row_strobe_in_n(row_strobe_in_n), .write_in_n(write_in_n), .cs_n(cs_n),
      .row_hold_select(row_hold_select), .address_latch_strobe(address_latch_strobe),
      .refresh_select_n(refresh_select_n), .refresh_clock_in(refresh_clock_in),
      .refresh_gen_clock(refresh_gen_clock), .row_addr_in(row_addr_in), .col_addr_in(col_addr_in),
      .bank_sel_lo(bank_sel_lo), .bank_sel_hi(bank_sel_hi), .refresh_request_n(refresh_request_n));
   dram_device_model u_model (.row_strobe_in_n(row_strobe_in_n), .cs_n(cs_n),
      .refresh_select_n(refresh_select_n), .refresh_clock_in(refresh_clock_in),
      .refresh_gen_clock(refresh_gen_clock), .refresh_request_n(refresh_request_n),
      .refresh_count(refresh_count));

   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results

   // One APB transfer; the expected answer is queued before the request goes out
   task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] d, input logic [31:0] m,
         input logic e);
      exp_q.push_back({e, d, m});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= adr;
      pwdata <= wr ? d : 32'h0000_0000;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so a following call never drives psel twice in one time step
      @(posedge clock);
   endtask : apb

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Reads the pre-edge values, so no race with the design's own updates
   always @(posedge clock) begin
      if (pready === 1'b1) begin
         if (exp_q.size() == 0) `CHECK(1'b1, 1'b0)
         else begin
            ex = exp_q.pop_front();
            `CHECK({pslverr, prdata & ex.mask}, {ex.err, ex.data & ex.mask})
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      results();
   end

   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, n_errors, n_compared} = '0;
      void'($urandom(28));
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      `CHECK({row_hold_select, address_latch_strobe, refresh_select_n, row_strobe_in_n, cs_n}, 5'h1F)
      apb(1'b0, `REG_CTRL, `CTRL_RESET_VAL, 32'hFFFF_FFFF, 1'b0);
      apb(1'b0, 12'hFFC, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
      // Accesses with both write levels and both row hold settings
      for (i = 0; i < 4; i++) begin
         // Start at a refresh clock rise: a forced refresh would make the address write busy and ignored
         for (t = 0; t < 2 * PERIOD && refresh_clock_in !== 1'b0; t++) @(posedge clock);
         for (t = 0; t < 2 * PERIOD && refresh_clock_in !== 1'b1; t++) @(posedge clock);
         a = $urandom & 32'h003F_FFFF;
         w = i[0];
         h = i[1];
         apb(1'b1, `REG_ADDR, a, 32'h0, 1'b0);
         apb(1'b1, `REG_CTRL, {27'h0, h, 2'b00, w, 1'b1}, 32'h0, 1'b0);
         for (t = 0; t < 100 && row_strobe_in_n !== 1'b0; t++) @(posedge clock);
         `CHECK({cs_n, write_in_n, row_hold_select}, {1'b0, ~w, h})
         `CHECK({bank_sel_hi, bank_sel_lo, col_addr_in, row_addr_in}, a[21:0])
         for (t = 0; t < 100 && row_strobe_in_n === 1'b0; t++) @(posedge clock);
         `CHECK(t, `STROBE_LOW_CYC)
         for (t = 0; t < 100 && cs_n === 1'b0; t++) @(posedge clock);
         apb(1'b0, `REG_STATUS, 32'h0000_0002, 32'h0000_0002, 1'b0);
         apb(1'b1, `REG_STATUS, 32'h0000_0002, 32'h0, 1'b0);
      end
      // Hidden refresh: exactly one in a whole refresh clock period
      apb(1'b1, `REG_CTRL, 32'h0000_0014, 32'h0, 1'b0);
      for (t = 0; t < 2 * PERIOD && refresh_clock_in !== 1'b0; t++) @(posedge clock);
      for (t = 0; t < 2 * PERIOD && refresh_clock_in !== 1'b1; t++) @(posedge clock);
      {c0, falls, prev, ok} = {refresh_count, 32'd0, 2'b11};
      for (t = 0; t < PERIOD; t++) begin
         @(posedge clock);
         if (prev === 1'b1 && row_strobe_in_n === 1'b0) falls++;
         if (row_strobe_in_n === 1'b0 && cs_n !== 1'b1) ok = 1'b0;
         prev = row_strobe_in_n;
      end
      `CHECK(falls, 1)
      `CHECK({ok, refresh_count - c0}, 9'h101)
      // Forced refresh in answer to a request
      apb(1'b1, `REG_CTRL, 32'h0000_0010, 32'h0, 1'b0);
      for (t = 0; t < 3 * PERIOD && refresh_request_n !== 1'b0; t++) @(posedge clock);
      {c0, ok} = {refresh_count, 1'b1};
      for (t = 0; t < 10 && refresh_select_n !== 1'b0; t++) @(posedge clock);
      `CHECK(refresh_select_n, 1'b0)
      for (t = 0; t < 60 && refresh_select_n === 1'b0; t++) begin
         if (row_strobe_in_n !== 1'b1 || cs_n !== 1'b1) ok = 1'b0;
         @(posedge clock);
      end
      `CHECK({ok, t >= 4 * `GEN_CLOCK_CYC}, 2'b11)
      `CHECK({refresh_request_n, refresh_clock_in, refresh_count - c0}, 10'h201)
      // External refresh with the refresh clock held high
      apb(1'b1, `REG_CTRL, 32'h0000_0018, 32'h0, 1'b0);
      {c0, ok} = {refresh_count, 1'b1};
      for (t = 0; t < 3 * PERIOD && refresh_select_n !== 1'b0; t++) @(posedge clock);
      for (t = 0; t < 40 && refresh_select_n === 1'b0; t++) begin
         if (refresh_clock_in !== 1'b1) ok = 1'b0;
         prev = row_strobe_in_n;
         @(posedge clock);
      end
      `CHECK({ok, prev, refresh_count - c0}, 10'h301)
      apb(1'b0, `REG_STATUS, {16'h0, refresh_count, 8'h00}, 32'h0000_FF00, 1'b0);
      apb(1'b1, `REG_CTRL, 32'h0000_0010, 32'h0, 1'b0);
      repeat (4) @(posedge clock);
      results();
   end
endmodule : dram_auto_access_refresh_bench
